// [rx_mode_defs.svh]
// Offsets, field positions, reset values and timing for the mode registers
`ifndef RX_MODE_DEFS_SVH
`define RX_MODE_DEFS_SVH

`define ADDR_SERIAL_ADDRESS_TRACE    8'h00
`define ADDR_SERIAL_DATA_TRACE       8'h01
`define ADDR_CHIP_MODE_CONTROL_0     8'h02
`define ADDR_CFGB_SYNC_A_LOW         8'ha6
`define ADDR_CFGB_SYNC_A_HIGH        8'ha7
`define ADDR_CFGB_SYNC_B_LOW         8'ha8
`define ADDR_CFGB_SYNC_B_HIGH        8'ha9
`define ADDR_CFGB_EOM_CONTROL        8'haa
`define ADDR_CFGB_MSG_LEN_LIMIT      8'hab
`define ADDR_PEAK_DETECTOR_1_LEVEL   8'hac
`define ADDR_PEAK_DETECTOR_2_LEVEL   8'had
`define ADDR_FSK_NOISE_POWER         8'haf
`define ADDR_ASK_NOISE_POWER         8'hb0
`define ADDR_CFGA_PRESLICER          8'hb4
`define ADDR_CFGB_PRESLICER          8'hb5
`define ADDR_CFGA_SIGDET_LOW         8'hb6
`define ADDR_CFGB_SIGDET_LOW         8'hb7
`define ADDR_CFGA_SIGDET_FACTOR      8'hb8
`define ADDR_CFGB_SIGDET_FACTOR      8'hb9

`define CHIP_MODE_CONTROL_0_OPERATING_MODE_SELECT   0
`define CHIP_MODE_CONTROL_0_SLAVE_RECEIVER_RUN      1
`define CHIP_MODE_CONTROL_0_DUAL_CONFIG_POLLING     2
`define CHIP_MODE_CONTROL_0_SLAVE_CONFIG_SELECT     3
`define CHIP_MODE_CONTROL_0_FIFO_LOCK_ON_MSG_END    4
`define CHIP_MODE_CONTROL_0_TIMEOUT_TIMER_ENABLE    5
`define CHIP_MODE_CONTROL_0_CLOCK_OUTPUT_ENABLE     6
`define CHIP_MODE_CONTROL_0_FIFO_INIT_AT_START      7

`define RESET_CHIP_MODE_CONTROL_0    8'h40
`define RESET_CONFIG                 8'h00
`define RESET_SIGDET_FACTOR          8'h0a

`define SERIAL_CMD_WRITE             8'h01
`define SERIAL_CMD_READ              8'h02

`define SYNC_TIMEOUT_US              100
`define SYS_CLK_MHZ                  100
`define CLOCK_OUTPUT_HALF_PERIOD     4

`endif

// [rx_mode_pkg.sv]
// Types shared by the chip mode control block
package rx_mode_pkg;

	typedef enum logic [1:0] {
		ST_SLEEP,
		ST_SLAVE_RUN,
		ST_POLL,
		ST_POLL_RUN
	} op_state_t;

	typedef struct packed {
		logic [15:0] cfgb_sync_pattern_a;
		logic [15:0] cfgb_sync_pattern_b;
		logic [7:0]  cfgb_end_of_message_control;
		logic [7:0]  cfgb_message_length_limit;
		logic [7:0]  cfga_preslicer_control;
		logic [7:0]  cfgb_preslicer_control;
		logic [7:0]  cfga_signal_detect_low_threshold;
		logic [7:0]  cfgb_signal_detect_low_threshold;
		logic [7:0]  cfga_signal_detect_factor;
		logic [7:0]  cfgb_signal_detect_factor;
	} rx_config_t;

	typedef struct packed {
		logic       wake_found;
		logic       poll_miss;
		logic       sync_found;
		logic       message_end;
	} rx_event_t;

	typedef struct packed {
		logic [7:0] peak_1;
		logic [7:0] peak_2;
		logic       peak_2_valid;
		logic [7:0] fsk_noise;
		logic [7:0] ask_noise;
	} rx_status_t;

endpackage

// [rx_chip_mode_control_regs.sv]
// Chip mode control, receiver configuration and status over the serial port
// Operation
// - Bit 0 of chip mode control picks slave run/sleep (0) or self polling (1).
// - In slave operation bit 1 keeps the receiver asleep (0) or in slave run (1).
// - In self polling bit 2 polls configuration A only (0) or A then B (1).
// - In slave operation bit 3 selects configuration A (0) or B (1).
// - With bit 4 set the data FIFO is locked at message end, otherwise never.
// - With bit 5 set a timeout returns the polling run phase to polling if no sync.
// - Bit 6 enables the programmable clock output.
// - With bit 7 set the FIFO is initialised on entering slave run or poll run.
// - A read-only register traces the last address seen on the serial port.
// - A read-only register traces the last data byte seen on the serial port.
// - Peak detector 1 level is a read-only status register resetting to zero.
// - Peak detector 2 level is cleared by reading it and resets to zero.
// - Both signal detector factor registers reset to 0x0a, chip mode control to 0x40, the rest to zero.
// - Configuration B holds two 16-bit sync patterns as low/high byte pairs.
// - Configuration B holds a write-only message length limit.
// - Each configuration has a write-only low signal detector threshold.
`timescale 1ns/1ps
`include "rx_mode_defs.svh"

module rx_chip_mode_control_regs #(
	parameter int TIMEOUT_CYCLES = `SYNC_TIMEOUT_US * `SYS_CLK_MHZ,
	parameter int CLK_HALF_PERIOD = `CLOCK_OUTPUT_HALF_PERIOD
) (
	input  wire logic                    SYS_CLK_I,
	input  wire logic                    RST_I,
	input  wire logic                    SPI_SCK_I,
	input  wire logic                    SPI_CS_N_I,
	input  wire logic                    SPI_MOSI_I,
	output logic                         SPI_MISO_O,
	input  rx_mode_pkg::rx_event_t       EVENT_I,
	input  rx_mode_pkg::rx_status_t      STATUS_I,
	output logic                         RX_RUN_O,
	output logic                         RX_POLLING_O,
	output logic                         CFG_B_ACTIVE_O,
	output logic                         FIFO_INIT_O,
	output logic                         FIFO_LOCK_O,
	output logic                         CLK_OUT_O,
	output rx_mode_pkg::rx_config_t      CFG_O
);
	import rx_mode_pkg::*;

	if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 32'h00ffffff)
		$error("TIMEOUT_CYCLES out of range");
	if (CLK_HALF_PERIOD < 1 || CLK_HALF_PERIOD > 255)
		$error("CLK_HALF_PERIOD out of range");

	// Serial pin synchronisers
	logic [2:0] sck_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] mosi_sync_reg;

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			sck_sync_reg  <= 3'h0;
			cs_sync_reg   <= 2'h3;
			mosi_sync_reg <= 2'h0;
		end
		else
		begin
			sck_sync_reg  <= {sck_sync_reg[1:0], SPI_SCK_I};
			cs_sync_reg   <= {cs_sync_reg[0], SPI_CS_N_I};
			mosi_sync_reg <= {mosi_sync_reg[0], SPI_MOSI_I};
		end
	end

	wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
	wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
	wire selected = ~cs_sync_reg[1];
	wire mosi_bit = mosi_sync_reg[1];

	// Serial framing: command byte, address byte, data byte
	logic [2:0] bit_cnt_reg;
	logic [1:0] byte_idx_reg;
	logic [7:0] rx_shift_reg;
	logic [7:0] tx_shift_reg;
	logic [7:0] cmd_reg;
	logic [7:0] addr_reg;
	logic       miso_reg;

	wire [7:0] byte_in   = {rx_shift_reg[6:0], mosi_bit};
	wire       byte_done = selected & sck_rise & (bit_cnt_reg == 3'h7);
	wire       cmd_done  = byte_done & (byte_idx_reg == 2'h0);
	wire       addr_done = byte_done & (byte_idx_reg == 2'h1);
	wire       data_done = byte_done & (byte_idx_reg == 2'h2);
	wire       wr_strobe = data_done & (cmd_reg == `SERIAL_CMD_WRITE);
	wire       rd_strobe = addr_done & (cmd_reg == `SERIAL_CMD_READ);

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I || !selected)
		begin
			bit_cnt_reg  <= 3'h0;
			byte_idx_reg <= 2'h0;
			rx_shift_reg <= 8'h00;
		end
		else if (sck_rise)
		begin
			bit_cnt_reg  <= bit_cnt_reg + 3'h1;
			rx_shift_reg <= byte_in;
			if (bit_cnt_reg == 3'h7 && byte_idx_reg != 2'h3)
				byte_idx_reg <= byte_idx_reg + 2'h1;
		end
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			cmd_reg  <= 8'h00;
			addr_reg <= 8'h00;
		end
		else
		begin
			if (cmd_done)
				cmd_reg <= byte_in;
			if (addr_done)
				addr_reg <= byte_in;
		end
	end

	// Mode control register and its fields
	logic [7:0] chip_mode_control_0_reg;
	wire operating_mode_select    =
		chip_mode_control_0_reg[`CHIP_MODE_CONTROL_0_OPERATING_MODE_SELECT];
	wire slave_receiver_run       =
		chip_mode_control_0_reg[`CHIP_MODE_CONTROL_0_SLAVE_RECEIVER_RUN];
	wire dual_config_polling      =
		chip_mode_control_0_reg[`CHIP_MODE_CONTROL_0_DUAL_CONFIG_POLLING];
	wire slave_config_select      =
		chip_mode_control_0_reg[`CHIP_MODE_CONTROL_0_SLAVE_CONFIG_SELECT];
	wire fifo_lock_on_message_end =
		chip_mode_control_0_reg[`CHIP_MODE_CONTROL_0_FIFO_LOCK_ON_MSG_END];
	wire timeout_timer_enable     =
		chip_mode_control_0_reg[`CHIP_MODE_CONTROL_0_TIMEOUT_TIMER_ENABLE];
	wire clock_output_enable      =
		chip_mode_control_0_reg[`CHIP_MODE_CONTROL_0_CLOCK_OUTPUT_ENABLE];
	wire fifo_init_at_cycle_start =
		chip_mode_control_0_reg[`CHIP_MODE_CONTROL_0_FIFO_INIT_AT_START];

	// Write-only configuration storage
	rx_config_t cfg_reg;
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			chip_mode_control_0_reg <= `RESET_CHIP_MODE_CONTROL_0;
			cfg_reg <= '0;
			cfg_reg.cfga_signal_detect_factor <= `RESET_SIGDET_FACTOR;
			cfg_reg.cfgb_signal_detect_factor <= `RESET_SIGDET_FACTOR;
		end
		else if (wr_strobe)
		begin
			unique case (addr_reg)
				`ADDR_CHIP_MODE_CONTROL_0:
					chip_mode_control_0_reg <= byte_in;
				`ADDR_CFGB_SYNC_A_LOW:
					cfg_reg.cfgb_sync_pattern_a[7:0] <= byte_in;
				`ADDR_CFGB_SYNC_A_HIGH:
					cfg_reg.cfgb_sync_pattern_a[15:8] <= byte_in;
				`ADDR_CFGB_SYNC_B_LOW:
					cfg_reg.cfgb_sync_pattern_b[7:0] <= byte_in;
				`ADDR_CFGB_SYNC_B_HIGH:
					cfg_reg.cfgb_sync_pattern_b[15:8] <= byte_in;
				`ADDR_CFGB_EOM_CONTROL:
					cfg_reg.cfgb_end_of_message_control <= byte_in;
				`ADDR_CFGB_MSG_LEN_LIMIT:
					cfg_reg.cfgb_message_length_limit <= byte_in;
				`ADDR_CFGA_PRESLICER:
					cfg_reg.cfga_preslicer_control <= byte_in;
				`ADDR_CFGB_PRESLICER:
					cfg_reg.cfgb_preslicer_control <= byte_in;
				`ADDR_CFGA_SIGDET_LOW:
					cfg_reg.cfga_signal_detect_low_threshold <= byte_in;
				`ADDR_CFGB_SIGDET_LOW:
					cfg_reg.cfgb_signal_detect_low_threshold <= byte_in;
				`ADDR_CFGA_SIGDET_FACTOR:
					cfg_reg.cfga_signal_detect_factor <= byte_in;
				`ADDR_CFGB_SIGDET_FACTOR:
					cfg_reg.cfgb_signal_detect_factor <= byte_in;
				default:
					;
			endcase
		end
	end

	// Status registers and serial tracers
	logic [7:0] serial_address_trace_reg;
	logic [7:0] serial_data_trace_reg;
	logic [7:0] peak_detector_1_level_reg;
	logic [7:0] peak_detector_2_level_reg;
	logic [7:0] fsk_noise_power_reg;
	logic [7:0] ask_noise_power_reg;

	wire peak_2_read = rd_strobe & (byte_in == `ADDR_PEAK_DETECTOR_2_LEVEL);
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			serial_address_trace_reg  <= 8'h00;
			serial_data_trace_reg     <= 8'h00;
			peak_detector_1_level_reg <= 8'h00;
			peak_detector_2_level_reg <= 8'h00;
			fsk_noise_power_reg       <= 8'h00;
			ask_noise_power_reg       <= 8'h00;
		end
		else
		begin
			if (addr_done)
				serial_address_trace_reg <= byte_in;
			if (data_done)
				serial_data_trace_reg <= byte_in;
			peak_detector_1_level_reg <= STATUS_I.peak_1;
			if (STATUS_I.peak_2_valid)
				peak_detector_2_level_reg <= STATUS_I.peak_2;
			else if (peak_2_read)
				peak_detector_2_level_reg <= 8'h00;
			fsk_noise_power_reg <= STATUS_I.fsk_noise;
			ask_noise_power_reg <= STATUS_I.ask_noise;
		end
	end

	// Read data; write-only and unmapped addresses read as zero
	logic [7:0] rd_data;
	always_comb
	begin
		unique case (byte_in)
			`ADDR_SERIAL_ADDRESS_TRACE:
				rd_data = serial_address_trace_reg;
			`ADDR_SERIAL_DATA_TRACE:
				rd_data = serial_data_trace_reg;
			`ADDR_PEAK_DETECTOR_1_LEVEL:
				rd_data = peak_detector_1_level_reg;
			`ADDR_PEAK_DETECTOR_2_LEVEL:
				rd_data = peak_detector_2_level_reg;
			`ADDR_FSK_NOISE_POWER: rd_data = fsk_noise_power_reg;
			`ADDR_ASK_NOISE_POWER: rd_data = ask_noise_power_reg;
			default:               rd_data = 8'h00;
		endcase
	end

	// Read shifter, MSB first, changed on falling clock
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I || !selected)
		begin
			tx_shift_reg <= 8'h00;
			miso_reg     <= 1'b0;
		end
		else if (rd_strobe)
			tx_shift_reg <= rd_data;
		else if (sck_fall)
		begin
			miso_reg     <= tx_shift_reg[7];
			tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
		end
	end

	// Operating mode state machine
	op_state_t state_reg;
	op_state_t state_next;
	logic      poll_cfg_b_reg;
	logic      poll_cfg_b_next;
	logic      fifo_init_reg;
	logic      fifo_lock_reg;
	logic [23:0] timeout_cnt_reg;
	wire timeout_hit = timeout_timer_enable &&
		(timeout_cnt_reg == 24'(TIMEOUT_CYCLES - 1));

	always_comb
	begin
		state_next      = state_reg;
		poll_cfg_b_next = poll_cfg_b_reg;
		unique case (state_reg)
			ST_SLEEP, ST_SLAVE_RUN:
			begin
				if (operating_mode_select)
				begin
					state_next      = ST_POLL;
					poll_cfg_b_next = 1'b0;
				end
				else if (slave_receiver_run)
					state_next = ST_SLAVE_RUN;
				else
					state_next = ST_SLEEP;
			end
			ST_POLL:
			begin
				if (!operating_mode_select)
					state_next = ST_SLEEP;
				else if (EVENT_I.wake_found)
					state_next = ST_POLL_RUN;
				else if (EVENT_I.poll_miss)
					poll_cfg_b_next = dual_config_polling &
						~poll_cfg_b_reg;
			end
			ST_POLL_RUN:
			begin
				if (!operating_mode_select)
					state_next = ST_SLEEP;
				else if (timeout_hit || EVENT_I.message_end)
				begin
					state_next      = ST_POLL;
					poll_cfg_b_next = 1'b0;
				end
			end
		endcase
	end

	wire enter_run = (state_next == ST_SLAVE_RUN && state_reg != ST_SLAVE_RUN)
		|| (state_next == ST_POLL_RUN && state_reg == ST_POLL);

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			state_reg      <= ST_SLEEP;
			poll_cfg_b_reg <= 1'b0;
			fifo_init_reg  <= 1'b0;
			fifo_lock_reg  <= 1'b0;
		end
		else
		begin
			state_reg      <= state_next;
			poll_cfg_b_reg <= poll_cfg_b_next;
			fifo_init_reg  <= enter_run & fifo_init_at_cycle_start;
			if (EVENT_I.message_end && fifo_lock_on_message_end &&
				(state_reg == ST_SLAVE_RUN || state_reg == ST_POLL_RUN))
				fifo_lock_reg <= 1'b1;
			else if (enter_run && fifo_init_at_cycle_start)
				fifo_lock_reg <= 1'b0;
		end
	end

	// Sync timeout counter, restarted by every sync found
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I || state_reg != ST_POLL_RUN || EVENT_I.sync_found
			|| !timeout_timer_enable || timeout_hit)
			timeout_cnt_reg <= 24'h000000;
		else
			timeout_cnt_reg <= timeout_cnt_reg + 24'h000001;
	end

	// Programmable clock output divider
	logic [7:0] clk_div_reg;
	logic       clk_out_reg;
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I || !clock_output_enable)
		begin
			clk_div_reg <= 8'h00;
			clk_out_reg <= 1'b0;
		end
		else if (clk_div_reg == 8'(CLK_HALF_PERIOD - 1))
		begin
			clk_div_reg <= 8'h00;
			clk_out_reg <= ~clk_out_reg;
		end
		else
			clk_div_reg <= clk_div_reg + 8'h01;
	end

	// Registered outputs
	logic rx_run_reg;
	logic polling_reg;
	logic cfg_b_reg;
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			rx_run_reg  <= 1'b0;
			polling_reg <= 1'b0;
			cfg_b_reg   <= 1'b0;
		end
		else
		begin
			rx_run_reg  <= (state_next == ST_SLAVE_RUN) ||
				(state_next == ST_POLL_RUN);
			polling_reg <= (state_next == ST_POLL);
			cfg_b_reg   <= (state_next == ST_SLAVE_RUN ||
				state_next == ST_SLEEP) ? slave_config_select
				: poll_cfg_b_next;
		end
	end

	assign SPI_MISO_O     = miso_reg;
	assign RX_RUN_O       = rx_run_reg;
	assign RX_POLLING_O   = polling_reg;
	assign CFG_B_ACTIVE_O = cfg_b_reg;
	assign FIFO_INIT_O    = fifo_init_reg;
	assign FIFO_LOCK_O    = fifo_lock_reg;
	assign CLK_OUT_O      = clk_out_reg;
	assign CFG_O          = cfg_reg;

endmodule // rx_chip_mode_control_regs

// [rx_mode_checker_assertions.sv]
// Port-level assertions for the chip mode control block
`timescale 1ns/1ps
module rx_mode_checker
	import rx_mode_pkg::*;
#(
	parameter int CLK_HALF_PERIOD = 4
) (
	input wire logic                   SYS_CLK_I,
	input wire logic                   RST_I,
	input wire logic                   SPI_CS_N_I,
	input wire logic                   SPI_MISO_O,
	input wire rx_mode_pkg::rx_event_t EVENT_I,
	input wire logic                   RX_RUN_O,
	input wire logic                   RX_POLLING_O,
	input wire logic                   FIFO_INIT_O,
	input wire logic                   FIFO_LOCK_O,
	input wire logic                   CLK_OUT_O,
	input wire rx_mode_pkg::rx_config_t CFG_O
);
	logic [7:0] lo_cnt;

	// Low-phase length of the clock output
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
			lo_cnt <= 8'hff;
		else if (CLK_OUT_O)
			lo_cnt <= 8'h00;
		else if (lo_cnt != 8'hff)
			lo_cnt <= lo_cnt + 8'h01;
	end

	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	init_pulse_a: assert property (FIFO_INIT_O |=> !FIFO_INIT_O)
		else $error("fifo init pulse too long");
	init_entry_a: assert property (
		FIFO_INIT_O |-> RX_RUN_O && !$past(RX_RUN_O))
		else $error("fifo init outside run entry");
	mode_excl_a: assert property (!(RX_RUN_O && RX_POLLING_O))
		else $error("run and polling together");
	wake_run_a: assert property (
		RX_POLLING_O && EVENT_I.wake_found |=> RX_RUN_O)
		else $error("wake found did not start run");
	lock_cause_a: assert property (
		$rose(FIFO_LOCK_O) |-> $past(EVENT_I.message_end && RX_RUN_O))
		else $error("fifo lock without message end");
	clk_half_a: assert property (
		$rose(CLK_OUT_O) |-> lo_cnt >= CLK_HALF_PERIOD)
		else $error("clock output low phase too short");
	miso_idle_a: assert property (SPI_CS_N_I [*4] |-> !SPI_MISO_O)
		else $error("serial out driven while idle");
	cfg_hold_a: assert property (SPI_CS_N_I [*5] |-> $stable(CFG_O))
		else $error("configuration changed without access");
	reset_cfg_a: assert property (disable iff (1'b0)
		RST_I |=> CFG_O == {80'h0, 16'h0a0a} && !RX_RUN_O)
		else $error("configuration reset values wrong");

	cover property (FIFO_INIT_O);
	cover property ($rose(FIFO_LOCK_O));
	cover property ($fell(RX_RUN_O) ##1 RX_POLLING_O);
endmodule // rx_mode_checker

bind rx_chip_mode_control_regs rx_mode_checker #(.CLK_HALF_PERIOD(CLK_HALF_PERIOD))
	rx_mode_checker_inst (.SYS_CLK_I, .RST_I, .SPI_CS_N_I, .SPI_MISO_O,
	.EVENT_I, .RX_RUN_O, .RX_POLLING_O, .FIFO_INIT_O, .FIFO_LOCK_O,
	.CLK_OUT_O, .CFG_O);

// [spi_host_model.sv]
// Host controller model driving the serial register port
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic clk_i,
	input  wire logic miso_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      mosi_o
);
	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Command, address, data; clock idles low, phases of six cycles
	task automatic xfer(input logic [7:0] cmd, adr, dat, output logic [7:0] rdat);
		logic [23:0] sh;
		sh = {cmd, adr, dat};
		rdat = 8'h00;
		cs_n_o <= 1'b0;
		tick(6);
		for (int i = 23; i >= 0; i--)
		begin
			mosi_o <= sh[i];
			tick(6);
			sck_o <= 1'b1;
			if (i < 8)
				rdat = {rdat[6:0], miso_i};
			tick(6);
			sck_o <= 1'b0;
		end
		tick(6);
		cs_n_o <= 1'b1;
		mosi_o <= ~sh[0];
		tick(6);
	endtask
endmodule // spi_host_model

// [rx_chip_mode_control_regs_tb.sv]
// Self-checking bench for the chip mode control block
`timescale 1ns/1ps
`include "rx_mode_defs.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
module rx_chip_mode_control_regs_tb;
	import rx_mode_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       sck, cs_n, mosi, miso, run, poll, cfgb, init, lock, clko;
	logic       clko_d;
	rx_event_t  ev = '0;
	rx_status_t st = '0;
	rx_config_t cfg, exp_cfg;
	int         fails = 0;
	int         checked = 0;
	int         inits = 0;
	logic [7:0] rd;
	logic [7:0] ad [12] = '{8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'haa, 8'hab,
		8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb9};

	always #5 clk = ~clk;
	always @(posedge clk) if (init) inits++;
	always @(posedge clk) clko_d <= clko;

	rx_chip_mode_control_regs #(.TIMEOUT_CYCLES(20)) rx_chip_mode_control_regs_inst (
		.SYS_CLK_I(clk), .RST_I(rst), .SPI_SCK_I(sck), .SPI_CS_N_I(cs_n),
		.SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .EVENT_I(ev), .STATUS_I(st),
		.RX_RUN_O(run), .RX_POLLING_O(poll), .CFG_B_ACTIVE_O(cfgb),
		.FIFO_INIT_O(init), .FIFO_LOCK_O(lock), .CLK_OUT_O(clko), .CFG_O(cfg));
	spi_host_model spi_host_model_inst (.clk_i(clk), .miso_i(miso),
		.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

	task automatic wr(input logic [7:0] a, d);
		spi_host_model_inst.xfer(`SERIAL_CMD_WRITE, a, d, rd);
	endtask
	task automatic rdchk(input string n, input logic [7:0] a, e);
		spi_host_model_inst.xfer(`SERIAL_CMD_READ, a, 8'hc3, rd);
		`CHK(n, e, rd)
	endtask
	task automatic pulse(input rx_event_t e);
		ev <= e;
		@(posedge clk);
		ev <= '0;
		@(posedge clk);
		@(posedge clk);
	endtask

	task automatic t_reset;
		int n;
		n = 0;
		exp_cfg = {80'h0, 8'h0a, 8'h0a};
		`CHK("cfg defaults", exp_cfg, cfg)
		`CHK("mode outputs", 4'b0000, {run, poll, cfgb, lock})
		repeat (20) @(posedge clk) if (clko !== clko_d) n++;
		`CHK("clock output toggles", 1'b1, n >= 4)
	endtask

	task automatic t_regs;
		for (int i = 0; i < 12; i++)
			wr(ad[i], ad[i] ^ 8'h5a);
		exp_cfg = {16'hfdfc, 16'hf3f2, 8'hf0, 8'hf1, 8'hee, 8'hef,
			8'hec, 8'hed, 8'he2, 8'he3};
		`CHK("cfg written", exp_cfg, cfg)
		rdchk("data trace", `ADDR_SERIAL_DATA_TRACE, 8'he3);
		// Tracer still holds the address of the previous read
		rdchk("address trace", `ADDR_SERIAL_ADDRESS_TRACE, 8'h01);
		rdchk("write-only read", 8'hb6, 8'h00);
		wr(8'hae, 8'h55);
		`CHK("cfg after reads", exp_cfg, cfg)
	endtask

	task automatic t_status;
		st <= '{8'h3c, 8'h77, 1'b1, 8'h21, 8'h12};
		@(posedge clk);
		st.peak_2_valid <= 1'b0;
		rdchk("peak 1", `ADDR_PEAK_DETECTOR_1_LEVEL, 8'h3c);
		rdchk("peak 2", `ADDR_PEAK_DETECTOR_2_LEVEL, 8'h77);
		rdchk("peak 2 cleared", `ADDR_PEAK_DETECTOR_2_LEVEL, 8'h00);
	endtask

	task automatic t_slave;
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'h02);
		`CHK("slave run", 3'b100, {run, poll, cfgb})
		`CHK("clock output off", 1'b0, clko)
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'h0a);
		`CHK("slave config b", 1'b1, cfgb)
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'h00);
		`CHK("sleep", 1'b0, run)
		inits = 0;
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'h92);
		`CHK("init pulses", 1, inits)
		pulse(4'b0001);
		`CHK("fifo locked", 1'b1, lock)
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'h00);
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'h82);
		`CHK("lock cleared by init", 1'b0, lock)
		pulse(4'b0001);
		`CHK("no lock when disabled", 1'b0, lock)
	endtask

	task automatic t_poll;
		int n;
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'h25);
		`CHK("polling", 2'b01, {run, poll})
		pulse(4'b0100);
		`CHK("dual toggles to b", 1'b1, cfgb)
		pulse(4'b1000);
		`CHK("run phase", 1'b1, run)
		n = 0;
		while (!poll && n < 60)
		begin
			@(posedge clk);
			n++;
		end
		`CHK("timeout to polling", 1'b1, poll && n >= 16)
		`CHK("back on config a", 1'b0, cfgb)
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'h21);
		pulse(4'b0100);
		`CHK("single config stays a", 1'b0, cfgb)
		// Wake with init, then syncs for longer than the timeout
		inits = 0;
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'ha1);
		pulse(4'b1000);
		`CHK("poll run init", 1, inits)
		repeat (8) pulse(4'b0010);
		`CHK("sync restarts timer", 1'b1, run)
		wr(`ADDR_CHIP_MODE_CONTROL_0, 8'h01);
		pulse(4'b1000);
		repeat (40) @(posedge clk);
		`CHK("no timeout when off", 1'b1, run)
		pulse(4'b0001);
		`CHK("message end ends run", 2'b01, {run, poll})
	endtask

	task automatic wrap_up;
		$display("Checks %0d errors %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset;
		t_regs;
		t_status;
		t_slave;
		t_poll;
		wrap_up;
	end

	initial
	begin
		#500us;
		fails++;
		wrap_up;
	end
endmodule // rx_chip_mode_control_regs_tb
